// ---- verilog/sld_defines.vh ----
// Functional notes
// - Display memory sits at 80H..95H of bank 4, reached via bank pointer 04H and indirect pointer.
// - Direct accesses to those addresses go to bank 0 general memory instead.
// - Each display bit drives one pixel: 1 on, 0 off.
// - Driver scans memory continuously; new data shows without software action.
// - Bits of unused commons store nothing and read back zero.
// - LCD clock is the low-speed clock divided by 8, about 4kHz.
// - Control bit 7 selects Type A when 0, Type B when 1.
// - Control bit 2 turns the charge pump on when 1.
// - Control bit 1 selects 1/3 duty when 0, 1/2 duty when 1.
// - With 1/2 duty the third common acts as an extra segment.
// - Control bit 0 enables display in normal and idle; sleep forces it off.
// - Programming mode forces display off and charge pump on.
// - Control bits 6..3 read zero; implemented bits reset to zero.
// - Display off or sleep resets display and drives outputs low; reset floats them.
// - Type B waveforms run at lower frequency than Type A.
`ifndef SLD_DEFINES_VH
`define SLD_DEFINES_VH
`define SLD_ADDR_CTRL 8'h00
`define SLD_ADDR_BANK 8'h04
`define SLD_ADDR_IPTR 8'h08
`define SLD_ADDR_IDATA 8'h0C
`define SLD_ADDR_DDATA 8'h10
`define SLD_ADDR_DPTR 8'h14
`define SLD_ADDR_STAT 8'h18
`define SLD_LCD_BANK 8'h04
`define SLD_MEM_FIRST 8'h80
`define SLD_MEM_LAST 8'h95
`define SLD_MEM_WORDS 22
`define SLD_BIT_TYPE 7
`define SLD_BIT_PUMP 2
`define SLD_BIT_DUTY 1
`define SLD_BIT_EN 0
`define SLD_CTRL_MASK 8'h87
`define SLD_CTRL_RESET 8'h00
`define SLD_LCD_DIV 8
`endif

// ---- verilog/sld_edge_sync.v ----
`timescale 1ns/10ps
// Two-stage synchroniser plus rising-edge pulse
module sld_edge_sync (
    input wire clk_sys, // System clock
    input wire rstn, // Async reset, active low
    input wire din, // Asynchronous level
    output wire rise // One-cycle pulse on rising edge
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    assign rise = s2_reg & ~s3_reg;
endmodule // sld_edge_sync

// ---- verilog/sld_segment_lcd.v ----
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "sld_defines.vh"
module sld_segment_lcd #(
    parameter NSEG = 21, // Segment outputs besides the third common
    parameter LCD_DIV = `SLD_LCD_DIV // Low-speed clock divide ratio
) (
    input wire clk_sys, // System clock, 10 MHz
    input wire rstn, // Async reset, active low
    input wire [7:0] avs_address, // Byte address
    input wire avs_read, // Read strobe
    input wire avs_write, // Write strobe
    input wire [31:0] avs_writedata, // Write data
    output reg [31:0] avs_readdata, // Read data
    output wire avs_waitrequest, // Wait request
    input wire low_speed_clock, // Low-speed subsystem clock
    input wire sleep_mode, // Device in sleep
    input wire in_circuit_programming, // Programming mode active
    output reg [2:0] com_out, // Common lines
    output reg [2:0] com_oe, // Common output enables
    output reg [NSEG-1:0] seg_out, // Segment lines
    output reg [NSEG-1:0] seg_oe, // Segment output enables
    output reg com2_seg_out, // Third common used as segment
    output reg charge_pump_on // Charge pump enable
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_DONE = 2'd2;

    reg [7:0] display_control_reg;
    reg [7:0] bank_pointer;
    reg [7:0] indirect_pointer;
    reg [7:0] direct_pointer;
    reg [7:0] lcd_mem [0:`SLD_MEM_WORDS-1];
    reg [7:0] gp_mem [0:`SLD_MEM_WORDS-1];
    reg [1:0] state_reg;
    reg [2:0] div_reg;
    reg [1:0] slot_reg;
    reg phase_reg;
    wire lcd_rise;
    wire lcd_tick;
    wire [7:0] ctrl_rd;
    wire in_lcd_range;
    wire ind_lcd;
    wire [4:0] ind_idx;
    wire [4:0] dir_idx;
    wire duty_half;
    wire disp_active;
    wire [7:0] mask_bits;
    reg [7:0] ind_rd;
    integer i;

    // Only 1/2 duty leaves unused commons; 1/3 keeps bits 0..2
    assign duty_half = display_control_reg[`SLD_BIT_DUTY];
    assign mask_bits = duty_half ? 8'h03 : 8'h07;
    assign ctrl_rd = display_control_reg & `SLD_CTRL_MASK;
    assign in_lcd_range = (indirect_pointer >= `SLD_MEM_FIRST) && (indirect_pointer <= `SLD_MEM_LAST);
    assign ind_lcd = in_lcd_range && (bank_pointer == `SLD_LCD_BANK);
    assign ind_idx = indirect_pointer[4:0] - 5'h00;
    assign dir_idx = direct_pointer[4:0];
    // Sleep or display bit off holds the driver in reset; programming forces it off too
    assign disp_active = display_control_reg[`SLD_BIT_EN] & ~sleep_mode & ~in_circuit_programming;

    // Two wait states; a write commits only on the edge that accepts it
    assign avs_waitrequest = (avs_read | avs_write) & (state_reg != ST_DONE);

    sld_edge_sync u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .din(low_speed_clock),
        .rise(lcd_rise)
    );

    // Divide the low-speed clock by eight
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 3'h0;
        end else if (!disp_active) begin
            div_reg <= 3'h0;
        end else if (lcd_rise) begin
            div_reg <= div_reg + 3'h1;
        end
    end
    assign lcd_tick = lcd_rise && (div_reg == LCD_DIV[2:0] - 3'h1);

    always @* begin
        ind_rd = 8'h00;
        if (ind_lcd) begin
            ind_rd = lcd_mem[ind_idx] & mask_bits;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            avs_readdata <= 32'h0;
            display_control_reg <= `SLD_CTRL_RESET;
            bank_pointer <= 8'h00;
            indirect_pointer <= 8'h00;
            direct_pointer <= 8'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (avs_read | avs_write) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    state_reg <= ST_DONE;
                    if (!avs_write) begin
                        case (avs_address)
                            `SLD_ADDR_CTRL: avs_readdata <= {24'h0, ctrl_rd};
                            `SLD_ADDR_BANK: avs_readdata <= {24'h0, bank_pointer};
                            `SLD_ADDR_IPTR: avs_readdata <= {24'h0, indirect_pointer};
                            `SLD_ADDR_IDATA: avs_readdata <= {24'h0, ind_rd};
                            `SLD_ADDR_DDATA: avs_readdata <= (dir_idx < `SLD_MEM_WORDS) ?
                                {24'h0, gp_mem[dir_idx]} : 32'h0;
                            `SLD_ADDR_DPTR: avs_readdata <= {24'h0, direct_pointer};
                            `SLD_ADDR_STAT: avs_readdata <= {28'h0, slot_reg, phase_reg, disp_active};
                            default: avs_readdata <= 32'h0;
                        endcase
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                    if (avs_write) begin
                        case (avs_address)
                            `SLD_ADDR_CTRL: display_control_reg <= avs_writedata[7:0] & `SLD_CTRL_MASK;
                            `SLD_ADDR_BANK: bank_pointer <= avs_writedata[7:0];
                            `SLD_ADDR_IPTR: indirect_pointer <= avs_writedata[7:0];
                            `SLD_ADDR_DPTR: direct_pointer <= avs_writedata[7:0];
                            default: ;
                        endcase
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Memory arrays carry no reset, like the real data memory
    always @(posedge clk_sys) begin
        if (state_reg == ST_DONE && avs_write) begin
            if (avs_address == `SLD_ADDR_IDATA && ind_lcd) begin
                lcd_mem[ind_idx] <= avs_writedata[7:0] & mask_bits;
            end
            if (avs_address == `SLD_ADDR_DDATA && dir_idx < `SLD_MEM_WORDS) begin
                gp_mem[dir_idx] <= avs_writedata[7:0];
            end
        end
    end

    // Frame sequencer: slot per common, phase inverts for zero DC
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            slot_reg <= 2'd0;
            phase_reg <= 1'b0;
        end else if (!disp_active) begin
            slot_reg <= 2'd0;
            phase_reg <= 1'b0;
        end else if (lcd_tick) begin
            // Type A flips phase inside each slot; Type B only per whole frame
            // Wrap on >= so a duty change in slot 2 cannot step into slot 3
            if (!display_control_reg[`SLD_BIT_TYPE]) begin
                phase_reg <= ~phase_reg;
                if (phase_reg) begin
                    slot_reg <= (slot_reg >= (duty_half ? 2'd1 : 2'd2)) ? 2'd0 : slot_reg + 2'd1;
                end
            end else begin
                if (slot_reg >= (duty_half ? 2'd1 : 2'd2)) begin
                    slot_reg <= 2'd0;
                    phase_reg <= ~phase_reg;
                end else begin
                    slot_reg <= slot_reg + 2'd1;
                end
            end
        end
    end

    // Outputs: digital level per line; bias analog is outside this block
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            com_out <= 3'h0;
            com_oe <= 3'h0;
            seg_out <= {NSEG{1'b0}};
            seg_oe <= {NSEG{1'b0}};
            com2_seg_out <= 1'b0;
            charge_pump_on <= 1'b0;
        end else begin
            charge_pump_on <= display_control_reg[`SLD_BIT_PUMP] | in_circuit_programming;
            com_oe <= 3'h7;
            seg_oe <= {NSEG{1'b1}};
            if (!disp_active) begin
                com_out <= 3'h0;
                seg_out <= {NSEG{1'b0}};
                com2_seg_out <= 1'b0;
            end else begin
                for (i = 0; i < 3; i = i + 1) begin
                    com_out[i] <= (slot_reg == i[1:0]) ^ phase_reg;
                end
                if (duty_half) begin
                    com_out[2] <= 1'b0;
                    com2_seg_out <= lcd_mem[NSEG][slot_reg[0]] ^ ~phase_reg;
                end else begin
                    com2_seg_out <= 1'b0;
                end
                for (i = 0; i < NSEG; i = i + 1) begin
                    seg_out[i] <= lcd_mem[i][slot_reg] ^ ~phase_reg;
                end
            end
        end
    end
endmodule // sld_segment_lcd

// ---- tb/sld_segment_lcd_monitor.sv ----
`timescale 1ns/10ps
module sld_segment_lcd_monitor #(parameter NSEG = 22) (
    input wire clk_sys, // Clock
    input wire rstn, // Reset
    input wire [7:0] avs_address, // Addr
    input wire avs_read, // Rd
    input wire avs_write, // Wr
    input wire [31:0] avs_readdata, // Rdata
    input wire avs_waitrequest, // Wait
    input wire sleep_mode, // Sleep
    input wire in_circuit_programming, // Prog
    input wire [2:0] com_out, // Com
    input wire [2:0] com_oe, // Com oe
    input wire [NSEG-1:0] seg_out, // Seg
    input wire [NSEG-1:0] seg_oe, // Seg oe
    input wire com2_seg_out, // Com2 seg
    input wire charge_pump_on // Pump
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    wire rd_done = avs_read && !avs_waitrequest;
    AST_ICP_PUMP: assert property (in_circuit_programming [*5] |-> charge_pump_on)
        else $error("pump off in programming");
    AST_ICP_DARK: assert property (in_circuit_programming [*5] |-> com_out == 3'h0 && seg_out == 0)
        else $error("display on in programming");
    AST_SLEEP_DARK: assert property (sleep_mode [*5] |-> !com2_seg_out && com_out == 3'h0 && seg_out == 0)
        else $error("display on in sleep");
    AST_OE_DRIVE: assert property ($past(rstn) |-> (&com_oe) && (&seg_oe))
        else $error("outputs float out of reset");
    AST_WAIT_BOUND: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
        else $error("no answer in time");
    AST_RD_UPPER: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_CTRL_RSVD: assert property (rd_done && avs_address == 8'h00 |-> avs_readdata[6:3] == 4'h0)
        else $error("reserved control bits set");
    AST_UNMAPPED: assert property (rd_done && avs_address == 8'h1C |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    cover property (rd_done);
    cover property (sleep_mode [*5]);
    cover property (in_circuit_programming [*5] ##1 charge_pump_on);
endmodule // sld_segment_lcd_monitor
bind sld_segment_lcd sld_segment_lcd_monitor #(.NSEG(NSEG)) sld_segment_lcd_monitor_inst (.clk_sys(clk_sys),
    .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
    .in_circuit_programming(in_circuit_programming), .com_out(com_out), .com_oe(com_oe), .seg_out(seg_out),
    .seg_oe(seg_oe), .com2_seg_out(com2_seg_out), .charge_pump_on(charge_pump_on));

// ---- tb/sld_panel_model.sv ----
`timescale 1ns/10ps
module sld_panel_model (
    input wire clk_sys, // Clock
    input wire clr, // Clear count
    input wire com0, // Common 0
    input wire com1, // Common 1
    input wire com2, // Common 2
    input wire seg0, // Segment 0
    output reg [15:0] diff_cnt // Cycles with voltage on pixel
);
    // Binary levels stand in for bias; only the pixel at common 0, segment 0
    // Common 0 counts as selected while it opposes both others (1/3 duty only)
    always @(posedge clk_sys) begin
        if (clr)
            diff_cnt <= 16'h0000;
        else if (com0 !== com1 && com0 !== com2 && com0 !== seg0)
            diff_cnt <= diff_cnt + 16'h0001;
    end
endmodule // sld_panel_model

// ---- tb/sld_segment_lcd_bench.sv ----
`timescale 1ns/10ps
module sld_segment_lcd_bench;
    reg clk_sys = 1'b0;
    reg rstn = 1'b0;
    reg [7:0] avs_address = 8'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg low_speed_clock = 1'b0;
    reg sleep_mode = 1'b0;
    reg in_circuit_programming = 1'b0;
    reg clr = 1'b1;
    reg [1:0] lsc_cnt = 2'h0;
    reg [31:0] q;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, com2_seg_out, charge_pump_on;
    wire [2:0] com_out, com_oe;
    wire [20:0] seg_out, seg_oe;
    wire [15:0] diff_cnt;
    integer bad_count = 0, comparisons = 0, ph_a, ph_b, mx, d_off;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        lsc_cnt <= lsc_cnt + 2'h1;
        if (lsc_cnt == 2'h3)
            low_speed_clock <= ~low_speed_clock;
    end
    sld_segment_lcd sld_segment_lcd_inst (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .low_speed_clock(low_speed_clock), .sleep_mode(sleep_mode),
        .in_circuit_programming(in_circuit_programming), .com_out(com_out), .com_oe(com_oe), .seg_out(seg_out),
        .seg_oe(seg_oe), .com2_seg_out(com2_seg_out), .charge_pump_on(charge_pump_on));
    sld_panel_model sld_panel_model_inst (.clk_sys(clk_sys), .clr(clr), .com0(com_out[0]), .com1(com_out[1]),
        .com2(com_out[2]), .seg0(seg_out[0]), .diff_cnt(diff_cnt));
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("FAIL %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task acc(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= w;
            avs_read <= !w;
            @(posedge clk_sys);
            @(negedge clk_sys);
            while (avs_waitrequest !== 1'b0) begin
                n = n + 1;
                if (n > 20) begin
                    bad_count = bad_count + 1;
                    end_sim;
                end
                @(negedge clk_sys);
            end
            // Settled mid-cycle; readdata holds through the accepting edge
            q = avs_readdata;
            @(posedge clk_sys);
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        acc(1'b1, a, d);
    endtask
    task rdc(input [7:0] a, input [31:0] e, input string nm);
        begin
            acc(1'b0, a, 32'h0);
            chk(nm, e, q);
        end
    endtask
    // Samples status for a span; counts phase flips and the highest slot
    task poll(output integer ph, output integer m);
        realtime t;
        reg last;
        begin
            t = $realtime;
            ph = 0;
            m = 0;
            acc(1'b0, 8'h18, 32'h0);
            last = q[1];
            while ($realtime < t + 64000.0) begin
                acc(1'b0, 8'h18, 32'h0);
                if (q[1] !== last)
                    ph = ph + 1;
                last = q[1];
                if (q[3:2] > m)
                    m = q[3:2];
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        chk("oe in reset", 32'h0, {com_oe, seg_oe});
        rstn <= 1'b1;
        @(posedge clk_sys);
        rdc(8'h00, 32'h0, "ctrl reset");
        chk("pump reset", 32'h0, charge_pump_on);
        wr(8'h00, 32'hFF);
        rdc(8'h00, 32'h87, "ctrl");
        chk("pump", 32'h1, charge_pump_on);
        wr(8'h00, 32'h05);
        wr(8'h04, 32'h04);
        wr(8'h08, 32'h80);
        wr(8'h0C, 32'hFF);
        rdc(8'h0C, 32'h07, "mem third");
        wr(8'h00, 32'h07);
        rdc(8'h0C, 32'h03, "mem half");
        wr(8'h14, 32'h80);
        wr(8'h10, 32'h5A);
        rdc(8'h10, 32'h5A, "direct");
        rdc(8'h0C, 32'h03, "mem kept");
        wr(8'h08, 32'h95);
        wr(8'h0C, 32'h01);
        rdc(8'h0C, 32'h01, "mem top");
        wr(8'h08, 32'h96);
        rdc(8'h0C, 32'h0, "mem past");
        wr(8'h04, 32'h00);
        wr(8'h08, 32'h80);
        rdc(8'h0C, 32'h0, "bank0");
        rdc(8'h1C, 32'h0, "unmapped");
        wr(8'h04, 32'h04);
        wr(8'h00, 32'h05);
        wr(8'h0C, 32'h00);
        clr <= 1'b0;
        repeat (768) @(posedge clk_sys);
        d_off = diff_cnt;
        chk("pixel off", 32'h0, d_off);
        wr(8'h0C, 32'h07);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (768) @(posedge clk_sys);
        chk("pixel on", 32'h1, diff_cnt > d_off);
        poll(ph_a, mx);
        chk("tick", 32'h1, ph_a >= 9 && ph_a <= 11);
        chk("slots third", 32'h2, mx);
        wr(8'h00, 32'h85);
        poll(ph_b, mx);
        chk("type b", 32'h1, ph_b < ph_a);
        wr(8'h00, 32'h07);
        repeat (256) @(posedge clk_sys);
        poll(ph_a, mx);
        chk("slots half", 32'h1, mx);
        wr(8'h00, 32'h04);
        repeat (2) @(posedge clk_sys);
        chk("off", 32'h0, {com_out, seg_out, com2_seg_out});
        wr(8'h00, 32'h05);
        sleep_mode <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("sleep", 32'h0, {com_out, seg_out, com2_seg_out});
        sleep_mode <= 1'b0;
        in_circuit_programming <= 1'b1;
        wr(8'h00, 32'h00);
        repeat (8) @(posedge clk_sys);
        chk("prog pump", 32'h1, charge_pump_on);
        end_sim;
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count = bad_count + 1;
        end_sim;
    end
endmodule // sld_segment_lcd_bench
